// ### hdl/dpsc_consts.vh
// constants for the potentiometer serial command decoder
// Behaviour
// - output echoes previous received frame
// - command b0 loads wiper from data
// - command e0 increments wiper by one
// - command 20 stores wiper to location zero
// - write protect low blocks nonvolatile writes
// - command 10 reloads wiper from location zero
// - reload wiper at reset and restore strobe
// - command c0 doubles the wiper
// - doubling clamps at full scale
// - command nibble 3 stores spare word
// - fourteen spare locations of sixteen bits
// - command nibble 9 fetches addressed word
// - command a0 prepares wiper readback
// - spare locations hold sixteen-bit words
// - stored location zero copied to the wiper register
`ifndef DPSC_CONSTS_VH
`define DPSC_CONSTS_VH
`define DPSC_FRAME_BITS   24
`define DPSC_WIPER_BITS   10
`define DPSC_WORD_BITS    16
`define DPSC_LOC_COUNT    16
`define DPSC_WIPER_FULL   10'h3ff
`define DPSC_WIPER_RESET  10'h200
`define DPSC_CMD_NOP      4'h0
`define DPSC_CMD_RESTORE  4'h1
`define DPSC_CMD_STORE    4'h2
`define DPSC_CMD_USER     4'h3
`define DPSC_CMD_RESTALL  4'h8
`define DPSC_CMD_READMEM  4'h9
`define DPSC_CMD_READWIP  4'ha
`define DPSC_CMD_WRITE    4'hb
`define DPSC_CMD_DOUBLE   4'hc
`define DPSC_CMD_INC      4'he
`endif

// ### hdl/dpsc_shifter.v
// serial frame shifter with echo output
`timescale 1ns/1ps
`include "dpsc_consts.vh"
module dpsc_shifter #(
    parameter FRAME_BITS = `DPSC_FRAME_BITS
) (
    // clock and reset
    input  wire                  clk_sys_in,
    input  wire                  rst_in,
    // serial link, sampled synchronously
    input  wire                  cs_n_in,
    input  wire                  sclk_in,
    input  wire                  sdi_in,
    output reg                   sdo_out,
    // frame side
    input  wire [FRAME_BITS-1:0] load_word_in,
    output reg  [FRAME_BITS-1:0] frame_out,
    output reg                   frame_valid_out
);
    // frame length at the counter's width, so the compare needs no cut
    localparam [7:0]      FRAME_COUNT = FRAME_BITS;
    reg  [FRAME_BITS-1:0] shift_reg;
    reg  [FRAME_BITS-1:0] out_reg;
    reg  [7:0]            count_reg;
    reg                   sclk_d_reg;
    reg                   cs_n_d_reg;
    wire                  rise = sclk_in & ~sclk_d_reg;
    wire                  fall = ~sclk_in & sclk_d_reg;
    wire                  cs_start = ~cs_n_in & cs_n_d_reg;
    wire                  cs_end = cs_n_in & ~cs_n_d_reg;

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            shift_reg       <= {FRAME_BITS{1'b0}};
            out_reg         <= {FRAME_BITS{1'b0}};
            count_reg       <= 8'h00;
            sclk_d_reg      <= 1'b0;
            cs_n_d_reg      <= 1'b1;
            sdo_out         <= 1'b0;
            frame_out       <= {FRAME_BITS{1'b0}};
            frame_valid_out <= 1'b0;
        end else begin
            sclk_d_reg      <= sclk_in;
            cs_n_d_reg      <= cs_n_in;
            frame_valid_out <= 1'b0;
            if (cs_start) begin
                // echo the last frame, or prepared readback, msb first
                out_reg   <= load_word_in;
                sdo_out   <= load_word_in[FRAME_BITS-1];
                count_reg <= 8'h00;
            end else if (!cs_n_in && rise) begin
                shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_in};
                count_reg <= count_reg + 8'h01;
            end else if (!cs_n_in && fall) begin
                out_reg <= {out_reg[FRAME_BITS-2:0], 1'b0};
                sdo_out <= out_reg[FRAME_BITS-2];
            end else if (cs_end) begin
                // partial or overlong frames are thrown away
                if (count_reg == FRAME_COUNT) begin
                    frame_out       <= shift_reg;
                    frame_valid_out <= 1'b1;
                end
            end
        end
    end
endmodule

// ### hdl/dpsc_decoder.v
// command decoder, wiper register and nonvolatile store
`timescale 1ns/1ps
`include "dpsc_consts.vh"
module dpsc_decoder #(
    parameter FRAME_BITS = `DPSC_FRAME_BITS,
    parameter WIPER_BITS = `DPSC_WIPER_BITS,
    parameter WORD_BITS  = `DPSC_WORD_BITS,
    parameter LOC_COUNT  = `DPSC_LOC_COUNT
) (
    // clock and reset
    input  wire                  clk_sys_in,
    input  wire                  rst_in,
    // serial link
    input  wire                  cs_n_in,
    input  wire                  sclk_in,
    input  wire                  sdi_in,
    output wire                  sdo_out,
    // control pins
    input  wire                  wp_n_in,
    input  wire                  restore_strobe_n_in,
    // state
    output reg  [WIPER_BITS-1:0] wiper_setting_out,
    output reg                   busy_out
);
    reg  [WORD_BITS-1:0]  nonvolatile_store [0:LOC_COUNT-1];
    reg  [WIPER_BITS-1:0] wiper_setting_reg;
    reg  [WIPER_BITS-1:0] wiper_setting_next;
    reg  [FRAME_BITS-1:0] echo_reg;
    reg                   boot_reg;
    reg                   strobe_d_reg;
    wire [FRAME_BITS-1:0] frame;
    wire                  frame_valid;
    wire [3:0]            cmd = frame[FRAME_BITS-1:FRAME_BITS-4];
    wire [3:0]            addr = frame[FRAME_BITS-5:FRAME_BITS-8];
    wire [WORD_BITS-1:0]  data = frame[WORD_BITS-1:0];
    wire [WORD_BITS-1:0]  loc0 = nonvolatile_store[0];
    wire                  strobe_fall = ~restore_strobe_n_in & strobe_d_reg;
    wire                  reload;
    integer               i;

    // commands that leave a readback or a reload pending until the next frame of any other command
    function is_busy_cmd;
        input [3:0] c;
        begin
            is_busy_cmd = (c == `DPSC_CMD_READMEM) || (c == `DPSC_CMD_READWIP) ||
                          (c == `DPSC_CMD_RESTORE);
        end
    endfunction

    // both restore codes copy location zero into the wiper
    function is_restore_cmd;
        input [3:0] c;
        begin
            is_restore_cmd = (c == `DPSC_CMD_RESTORE) || (c == `DPSC_CMD_RESTALL);
        end
    endfunction

    // location 0 holds the wiper copy and location 1 is left unused; neither takes user data
    function is_spare_addr;
        input [3:0] a;
        begin
            is_spare_addr = (a >= 4'h2);
        end
    endfunction

    dpsc_shifter #(
        .FRAME_BITS     (FRAME_BITS)
    ) u_shift (
        .clk_sys_in     (clk_sys_in),
        .rst_in         (rst_in),
        .cs_n_in        (cs_n_in),
        .sclk_in        (sclk_in),
        .sdi_in         (sdi_in),
        .sdo_out        (sdo_out),
        .load_word_in   (echo_reg),
        .frame_out      (frame),
        .frame_valid_out(frame_valid)
    );

    // boot pass stands in for power-up refresh
    assign reload = boot_reg | strobe_fall |
                    (frame_valid && is_restore_cmd(cmd));

    always @* begin
        wiper_setting_next = wiper_setting_reg;
        if (reload) begin
            wiper_setting_next = loc0[WIPER_BITS-1:0];
        end else if (frame_valid) begin
            case (cmd)
                `DPSC_CMD_WRITE: wiper_setting_next = data[WIPER_BITS-1:0];
                `DPSC_CMD_INC: begin
                    if (wiper_setting_reg != `DPSC_WIPER_FULL) begin
                        wiper_setting_next = wiper_setting_reg + 10'h001;
                    end
                end
                `DPSC_CMD_DOUBLE: begin
                    // top bit set means the shift would overflow
                    if (wiper_setting_reg[WIPER_BITS-1]) begin
                        wiper_setting_next = `DPSC_WIPER_FULL;
                    end else begin
                        wiper_setting_next = {wiper_setting_reg[WIPER_BITS-2:0], 1'b0};
                    end
                end
                default: wiper_setting_next = wiper_setting_reg;
            endcase
        end
    end

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            wiper_setting_reg <= `DPSC_WIPER_RESET;
            wiper_setting_out <= `DPSC_WIPER_RESET;
            echo_reg          <= {FRAME_BITS{1'b0}};
            boot_reg          <= 1'b1;
            strobe_d_reg      <= 1'b1;
            busy_out          <= 1'b0;
        end else begin
            boot_reg          <= 1'b0;
            strobe_d_reg      <= restore_strobe_n_in;
            wiper_setting_reg <= wiper_setting_next;
            wiper_setting_out <= wiper_setting_next;
            if (frame_valid) begin
                // readbacks replace the echo; any command other than 1, 9 or a returns to idle
                busy_out <= is_busy_cmd(cmd);
                if (cmd == `DPSC_CMD_READMEM) begin
                    echo_reg <= {frame[FRAME_BITS-1:WORD_BITS],
                                 nonvolatile_store[addr]};
                end else if (cmd == `DPSC_CMD_READWIP) begin
                    echo_reg <= {frame[FRAME_BITS-1:WORD_BITS],
                                 {(WORD_BITS-WIPER_BITS){1'b0}},
                                 wiper_setting_reg};
                end else begin
                    echo_reg <= frame;
                end
            end
        end
    end

    // store has no reset: contents survive like nonvolatile cells
    initial begin
        for (i = 0; i < LOC_COUNT; i = i + 1) begin
            nonvolatile_store[i] = {WORD_BITS{1'b0}};
        end
    end

    always @(posedge clk_sys_in) begin
        if (!rst_in && frame_valid && wp_n_in) begin
            if (cmd == `DPSC_CMD_STORE) begin
                nonvolatile_store[0] <= {{(WORD_BITS-WIPER_BITS){1'b0}},
                                         wiper_setting_reg};
            end else if (cmd == `DPSC_CMD_USER && is_spare_addr(addr)) begin
                nonvolatile_store[addr] <= data;
            end
        end
    end
endmodule

// ### bench/dpsc_props.sv
// pin-level checker for the command decoder
`timescale 1ns/1ps
module dpsc_props (
    // clock and reset
    input wire       clk_sys_in,
    input wire       rst_in,
    // pins
    input wire       cs_n_in,
    input wire       sclk_in,
    input wire       sdi_in,
    input wire       sdo_out,
    input wire       wp_n_in,
    input wire       restore_strobe_n_in,
    input wire [9:0] wiper_setting_out,
    input wire       busy_out
);
    reg        cs_q, ck_q;
    reg [23:0] sh_reg, pf_reg;
    reg [4:0]  n_reg;
    reg [9:0]  w_reg;
    wire       fin = cs_n_in && !cs_q;
    wire       ok = fin && n_reg == 5'd24;
    wire [7:0] op = sh_reg[23:16];
    wire [9:0] w1 = w_reg + 10'h1;
    // frames are rebuilt here so the write, increment, double, echo and busy checks key off what the host really sent
    always @(posedge clk_sys_in) begin
        cs_q <= rst_in | cs_n_in;
        ck_q <= sclk_in;
        if (cs_n_in)
            n_reg <= 5'd0;
        else if (sclk_in && !ck_q) begin
            sh_reg <= {sh_reg[22:0], sdi_in};
            n_reg  <= n_reg + 5'd1;
        end
        if (ok)
            pf_reg <= sh_reg;
        if (ok)
            w_reg <= wiper_setting_out;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    property p_wr; ok && op == 8'hb0 |-> ##[1:4] wiper_setting_out == sh_reg[9:0]; endproperty
    a_wr: assert property (p_wr) else $error("write");
    property p_inc; ok && op == 8'he0 |-> ##[1:4] wiper_setting_out == (&w_reg ? w_reg : w1);
    endproperty
    a_inc: assert property (p_inc) else $error("increment");
    property p_dbl; ok && op == 8'hc0 |-> ##[1:4]
        wiper_setting_out == (w_reg[9] ? 10'h3ff : {w_reg[8:0], 1'b0}); endproperty
    a_dbl: assert property (p_dbl) else $error("double");
    property p_bad; fin && n_reg != 5'd24 |=> $stable(wiper_setting_out) [*4]; endproperty
    a_bad: assert property (p_bad) else $error("short frame");
    property p_hold; !cs_n_in && $past(!cs_n_in, 3) |-> $stable(wiper_setting_out); endproperty
    a_hold: assert property (p_hold) else $error("mid frame");
    property p_sdo; !cs_n_in && sclk_in && $past(sclk_in) |-> $stable(sdo_out); endproperty
    a_sdo: assert property (p_sdo) else $error("sdo moved");
    property p_msb; $fell(cs_n_in) && pf_reg[23:20] != 4'h9 && pf_reg[23:20] != 4'ha
        |-> ##[1:3] sdo_out == pf_reg[23]; endproperty
    a_msb: assert property (p_msb) else $error("echo msb");
    property p_busy; ok |-> ##[1:4]
        busy_out == (op == 8'h10 || op[7:4] == 4'h9 || op == 8'ha0); endproperty
    a_busy: assert property (p_busy) else $error("busy");
endmodule
bind dpsc_decoder dpsc_props props_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cs_n_in(cs_n_in), .sclk_in(sclk_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
    .wp_n_in(wp_n_in), .restore_strobe_n_in(restore_strobe_n_in),
    .wiper_setting_out(wiper_setting_out), .busy_out(busy_out));

// ### bench/dpsc_host.sv
// serial host model driving frames into the decoder
`timescale 1ns/1ps
module dpsc_host (
    // clock
    input  wire clk_sys_in,
    // serial link
    output reg  cs_n_out,
    output reg  sclk_out,
    output reg  sdi_out,
    input  wire sdo_in
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out  = 1'b0;
    end
    task step(input integer k);
        begin
            repeat (k) @(posedge clk_sys_in);
            #5;
        end
    endtask
    // four clocks a phase keep the synchronised edge detect well clear
    task xfer(input [23:0] tx, input integer n, output [23:0] rx);
        integer i;
        begin
            rx = 24'h0;
            step(1);
            cs_n_out = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                sdi_out = tx[23 - i];
                step(4);
                rx = {rx[22:0], sdo_in};
                sclk_out = 1'b1;
                step(4);
                sclk_out = 1'b0;
            end
            step(4);
            cs_n_out = 1'b1;
            sdi_out  = ~sdi_out;
            step(6);
        end
    endtask
endmodule

// ### bench/dpsc_decoder_tb.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
module dpsc_decoder_tb;
    reg         clk_sys_in, rst_in, wp_n_in, restore_strobe_n_in;
    wire        cs_n, sclk, sdi, sdo, busy;
    wire [9:0]  wiper;
    reg  [23:0] rx;
    integer     failures, samples_checked;
    dpsc_host host_u (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n), .sclk_out(sclk),
        .sdi_out(sdi), .sdo_in(sdo));
    dpsc_decoder dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n),
        .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .wp_n_in(wp_n_in),
        .restore_strobe_n_in(restore_strobe_n_in), .wiper_setting_out(wiper), .busy_out(busy));
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task chk(input [23:0] seen, input [23:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checked %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // an all-x echo expectation means the echo is not judged
    task fr(input [23:0] tx, input [23:0] er, input [9:0] ew);
        begin
            host_u.xfer(tx, 24, rx);
            if (er !== 24'hxxxxxx)
                chk(rx, er);
            chk({14'h0, wiper}, {14'h0, ew});
        end
    endtask
    task t_inc;
        begin
            fr(24'hb00100, 24'hxxxxxx, 10'h100);
            fr(24'he05a5a, 24'hb00100, 10'h101);
            fr(24'he00000, 24'he05a5a, 10'h102);
            $display("test inc done");
        end
    endtask
    task t_nv;
        begin
            fr(24'h200000, 24'he00000, 10'h102);
            fr(24'hb00005, 24'h200000, 10'h005);
            fr(24'h100000, 24'hb00005, 10'h102);
            chk({23'h0, busy}, 24'h1);
            fr(24'h000000, 24'h100000, 10'h102);
            chk({23'h0, busy}, 24'h0);
            fr(24'hb00009, 24'h000000, 10'h009);
            restore_strobe_n_in = 1'b0;
            host_u.step(2);
            restore_strobe_n_in = 1'b1;
            host_u.step(6);
            chk({14'h0, wiper}, 24'h102);
            fr(24'hb00033, 24'hb00009, 10'h033);
            wp_n_in = 1'b0;
            fr(24'h200000, 24'hb00033, 10'h033);
            wp_n_in = 1'b1;
            fr(24'h100000, 24'h200000, 10'h102);
            fr(24'h000000, 24'h100000, 10'h102);
            $display("test store done");
        end
    endtask
    task t_user;
        begin
            fr(24'h32aaaa, 24'h000000, 10'h102);
            fr(24'h335555, 24'h32aaaa, 10'h102);
            fr(24'h3f1234, 24'h335555, 10'h102);
            fr(24'h920000, 24'h3f1234, 10'h102);
            fr(24'h930000, 24'h92aaaa, 10'h102);
            fr(24'h9f0000, 24'h935555, 10'h102);
            fr(24'h000000, 24'h9f1234, 10'h102);
            $display("test user done");
        end
    endtask
    task t_dbl;
        begin
            fr(24'hb00180, 24'h000000, 10'h180);
            fr(24'hc00000, 24'hb00180, 10'h300);
            fr(24'hb00200, 24'hc00000, 10'h200);
            fr(24'hc00000, 24'hb00200, 10'h3ff);
            fr(24'he00000, 24'hc00000, 10'h3ff);
            fr(24'ha00000, 24'he00000, 10'h3ff);
            fr(24'h00abcd, 24'ha003ff, 10'h3ff);
            host_u.xfer(24'hb00011, 23, rx);
            chk({14'h0, wiper}, 24'h3ff);
            fr(24'h000000, 24'h00abcd, 10'h3ff);
            $display("test double done");
        end
    endtask
    initial begin
        rst_in = 1'b1;
        wp_n_in = 1'b1;
        restore_strobe_n_in = 1'b1;
        failures = 0;
        samples_checked = 0;
        host_u.step(2);
        rst_in = 1'b0;
        host_u.step(3);
        chk({14'h0, wiper}, 24'h0);
        t_inc;
        t_nv;
        t_user;
        t_dbl;
        conclude;
    end
    initial begin
        #1000000;
        failures = failures + 1;
        conclude;
    end
endmodule
